// ### design/mpi_mac_port.sv
// MAC end of the media pin port: frame stores, link serdes, crossings
`timescale 1ns/100ps
module mpi_mac_port #(
  parameter int DEPTH = mpi_pkg::MPI_DEPTH_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire mpi_pkg::mpi_mode_t mode,
  input wire logic phyEmulation,
  input wire logic txWrite,
  input wire logic [7:0] txByte,
  input wire logic txLast,
  output logic txReady,
  output logic rxValid,
  output logic [9:0] rxWord,
  output logic rxLast,
  output logic rxError,
  output logic rxFalseCarrier,
  output logic carrierSeen,
  mpi_media_if.device_end media
);
  localparam int AW = $clog2(DEPTH);
  typedef enum {MPI_UT_FILL, MPI_UT_WAIT} mpi_ut_t;
  typedef enum {MPI_LT_IDLE, MPI_LT_SEND} mpi_lt_t;
  typedef enum {MPI_LR_IDLE, MPI_LR_GATHER, MPI_LR_HOLD} mpi_lr_t;
  typedef enum {MPI_UR_IDLE, MPI_UR_DRAIN} mpi_ur_t;

  // ----------------------------------------------------------------
  // Level crossings
  // ----------------------------------------------------------------
  logic rstMeta, rstLink;
  logic [1:0] modeMeta;
  logic [1:0] modeLinkBits;
  logic emuMeta, emuLink;
  logic carrierMeta, carrierSync;
  mpi_pkg::mpi_mode_t modeLink;

  // Reset and static config into the link domain
  always_ff @(posedge media.linkClock)
  begin
    rstMeta <= rst;
    rstLink <= rstMeta;
    modeMeta <= mode;
    modeLinkBits <= modeMeta;
    emuMeta <= phyEmulation;
    emuLink <= emuMeta;
  end
  assign modeLink = mpi_pkg::mpi_mode_t'(modeLinkBits);

  // Carrier sense is asynchronous to the user clock, so two flops first
  always_ff @(posedge clock)
  begin
    carrierMeta <= media.portCarrierSense;
    carrierSync <= carrierMeta;
  end
  assign carrierSeen = carrierSync;

  // ----------------------------------------------------------------
  // Transmit frame store, user side
  // ----------------------------------------------------------------
  logic [7:0] txMem [DEPTH];
  logic [AW:0] txCount, next_txCount;
  logic txGo, next_txGo;
  logic txDone, txDoneMeta, txDoneSync;
  mpi_ut_t utState, next_utState;

  assign txReady = (utState == MPI_UT_FILL) && (txCount < (AW+1)'(DEPTH));

  // A whole frame is stored first so enable never gaps mid-frame
  always_comb
  begin
    next_txCount = txCount;
    next_txGo = txGo;
    next_utState = utState;
    case (utState)
      MPI_UT_FILL:
      begin
        if (txWrite && txReady)
        begin
          next_txCount = txCount + 1'b1;
          if (txLast)
          begin
            next_txGo = ~txGo;
            next_utState = MPI_UT_WAIT;
          end
        end
      end
      MPI_UT_WAIT:
      begin
        if (txDoneSync == txGo)
        begin
          next_txCount = '0;
          next_utState = MPI_UT_FILL;
        end
      end
      default: next_utState = MPI_UT_FILL;
    endcase
  end

  // User transmit registers and store writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      txCount <= '0;
      txGo <= 1'b0;
      utState <= MPI_UT_FILL;
      txDoneMeta <= 1'b0;
      txDoneSync <= 1'b0;
    end
    else
    begin
      txCount <= next_txCount;
      txGo <= next_txGo;
      utState <= next_utState;
      txDoneMeta <= txDone;
      txDoneSync <= txDoneMeta;
    end
    if (txWrite && txReady)
    begin
      txMem[txCount[AW-1:0]] <= txByte;
    end
  end

  // ----------------------------------------------------------------
  // Transmit serialiser, link side
  // ----------------------------------------------------------------
  logic txGoMeta, txGoSync;
  logic next_txDone;
  logic [AW:0] txIdx, next_txIdx;
  logic [1:0] txSym, next_txSym;
  logic [7:0] pinData, next_pinData;
  logic pinEnable, next_pinEnable;
  logic [3:0] clkDiv, next_clkDiv;
  logic clkOut, next_clkOut;
  mpi_lt_t ltState, next_ltState;
  logic [7:0] curByte;

  assign curByte = txMem[txIdx[AW-1:0]];

  // Pins are registered, so each symbol launches on a rising link edge
  always_comb
  begin
    next_txDone = txDone;
    next_txIdx = txIdx;
    next_txSym = txSym;
    next_ltState = ltState;
    next_pinData = mpi_pkg::MPI_DATA_RESET;
    next_pinEnable = 1'b0;
    case (ltState)
      MPI_LT_IDLE:
      begin
        // Count is stable while the go toggle is pending
        if ((txGoSync != txDone) && (txCount != '0))
        begin
          next_txIdx = '0;
          next_txSym = '0;
          next_ltState = MPI_LT_SEND;
        end
      end
      MPI_LT_SEND:
      begin
        next_pinData = (curByte >> (txSym * mpi_pkg::laneWidth(modeLink))) & mpi_pkg::laneMask(modeLink);
        next_pinEnable = 1'b1;
        if (txSym == mpi_pkg::lastSymbol(modeLink))
        begin
          next_txSym = '0;
          next_txIdx = txIdx + 1'b1;
          if (txIdx == txCount - 1'b1)
          begin
            next_txDone = txGoSync;
            next_ltState = MPI_LT_IDLE;
          end
        end
        else
        begin
          next_txSym = txSym + 1'b1;
        end
      end
      default: next_ltState = MPI_LT_IDLE;
    endcase
    // Divider for the MII transmit clock when emulating a PHY
    next_clkDiv = clkDiv + 1'b1;
    next_clkOut = clkOut;
    if (clkDiv == 4'(mpi_pkg::MPI_TXCLK_HALF - 1))
    begin
      next_clkDiv = '0;
      next_clkOut = ~clkOut;
    end
  end

  // Link transmit registers
  always_ff @(posedge media.linkClock)
  begin
    if (rstLink)
    begin
      txGoMeta <= 1'b0;
      txGoSync <= 1'b0;
      txDone <= 1'b0;
      txIdx <= '0;
      txSym <= '0;
      ltState <= MPI_LT_IDLE;
      pinData <= mpi_pkg::MPI_DATA_RESET;
      pinEnable <= 1'b0;
      clkDiv <= '0;
      clkOut <= 1'b0;
    end
    else
    begin
      txGoMeta <= txGo;
      txGoSync <= txGoMeta;
      txDone <= next_txDone;
      txIdx <= next_txIdx;
      txSym <= next_txSym;
      ltState <= next_ltState;
      pinData <= next_pinData;
      pinEnable <= next_pinEnable;
      clkDiv <= next_clkDiv;
      clkOut <= next_clkOut;
    end
  end

  // Emulation steers the stream onto the receive pins toward the MAC
  assign media.portTransmitDataBus = emuLink ? mpi_pkg::MPI_DATA_RESET : pinData;
  assign media.portTransmitEnable = pinEnable & ~emuLink;
  assign media.devRxData = pinData;
  assign media.devRxValid = pinEnable;
  assign media.devRxError = 1'b0;
  assign media.devRxOe = emuLink;
  assign media.devCarrierOut = (modeLink == mpi_pkg::MPI_TBI) | pinEnable;
  assign media.devCarrierOe = emuLink;
  assign media.txClockOut = clkOut;
  assign media.txClockOe = emuLink && (modeLink == mpi_pkg::MPI_MII);

  // ----------------------------------------------------------------
  // Receive gatherer, link side
  // ----------------------------------------------------------------
  logic [9:0] rxMem [DEPTH];
  logic [7:0] smpData;
  logic smpValid, smpError, smpDetect;
  logic [7:0] acc, next_acc;
  logic [1:0] rxSym, next_rxSym;
  logic [AW:0] wrIdx, next_wrIdx;
  logic errSeen, next_errSeen;
  logic fcSeen, next_fcSeen;
  logic rxDone, next_rxDone;
  logic rxAck, next_rxAck, rxAckMeta, rxAckSync;
  logic memWrite;
  logic [9:0] memWord;
  logic active;
  logic [7:0] lanes;
  mpi_lr_t lrState, next_lrState;

  // TBI frames follow line detect, sampled with the data so the two stay aligned
  assign active = (modeLink == mpi_pkg::MPI_TBI) ? smpDetect : smpValid;
  assign lanes = smpData & mpi_pkg::laneMask(modeLink);

  always_comb
  begin
    next_acc = acc;
    next_rxSym = rxSym;
    next_wrIdx = wrIdx;
    next_errSeen = errSeen;
    next_fcSeen = fcSeen;
    next_rxDone = rxDone;
    next_lrState = lrState;
    memWrite = 1'b0;
    memWord = '0;
    case (lrState)
      MPI_LR_IDLE, MPI_LR_GATHER:
      begin
        if (active && !emuLink)
        begin
          next_lrState = MPI_LR_GATHER;
          if (modeLink == mpi_pkg::MPI_TBI)
          begin
            memWord = {smpError, smpValid, smpData};
            memWrite = 1'b1;
          end
          else
          begin
            next_errSeen = errSeen | smpError;
            next_acc = acc | 8'(lanes << (rxSym * mpi_pkg::laneWidth(modeLink)));
            next_rxSym = rxSym + 1'b1;
            if (rxSym == mpi_pkg::lastSymbol(modeLink))
            begin
              memWord = {2'b00, next_acc};
              memWrite = 1'b1;
              next_acc = '0;
              next_rxSym = '0;
            end
          end
          // A full store drops the tail and flags the frame
          if (memWrite && (wrIdx == (AW+1)'(DEPTH)))
          begin
            memWrite = 1'b0;
            next_errSeen = 1'b1;
          end
          next_wrIdx = wrIdx + (AW+1)'(memWrite);
        end
        else if (lrState == MPI_LR_GATHER)
        begin
          next_acc = '0;
          next_rxSym = '0;
          next_lrState = (wrIdx != '0) ? MPI_LR_HOLD : MPI_LR_IDLE;
          next_rxDone = (wrIdx != '0) ? ~rxDone : rxDone;
        end
        else if (smpError && !emuLink && (modeLink != mpi_pkg::MPI_TBI))
        begin
          memWord = {2'b00, lanes};
          memWrite = 1'b1;
          next_wrIdx = (AW+1)'(1);
          next_fcSeen = 1'b1;
          next_rxDone = ~rxDone;
          next_lrState = MPI_LR_HOLD;
        end
      end
      MPI_LR_HOLD:
      begin
        // Frames arriving while the user drains are lost
        if (rxAckSync == rxDone)
        begin
          next_wrIdx = '0;
          next_errSeen = 1'b0;
          next_fcSeen = 1'b0;
          next_lrState = MPI_LR_IDLE;
        end
      end
      default: next_lrState = MPI_LR_IDLE;
    endcase
  end

  // Receive pins sampled on the rising link edge
  always_ff @(posedge media.linkClock)
  begin
    if (rstLink)
    begin
      smpData <= mpi_pkg::MPI_DATA_RESET;
      smpValid <= 1'b0;
      smpError <= 1'b0;
      smpDetect <= 1'b0;
      acc <= '0;
      rxSym <= '0;
      wrIdx <= '0;
      errSeen <= 1'b0;
      fcSeen <= 1'b0;
      rxDone <= 1'b0;
      rxAckMeta <= 1'b0;
      rxAckSync <= 1'b0;
      lrState <= MPI_LR_IDLE;
    end
    else
    begin
      smpData <= media.portReceiveDataBus;
      smpValid <= media.portReceiveValid;
      smpError <= media.portReceiveError;
      smpDetect <= media.portCarrierSense;
      acc <= next_acc;
      rxSym <= next_rxSym;
      wrIdx <= next_wrIdx;
      errSeen <= next_errSeen;
      fcSeen <= next_fcSeen;
      rxDone <= next_rxDone;
      rxAckMeta <= rxAck;
      rxAckSync <= rxAckMeta;
      lrState <= next_lrState;
    end
    if (memWrite)
    begin
      rxMem[wrIdx[AW-1:0]] <= memWord;
    end
  end

  // ----------------------------------------------------------------
  // Receive drain, user side
  // ----------------------------------------------------------------
  logic rxDoneMeta, rxDoneSync;
  logic [AW:0] rdIdx, next_rdIdx;
  logic next_rxValid, next_rxLast, next_rxError, next_rxFc;
  logic [9:0] next_rxWord;
  mpi_ur_t urState, next_urState;

  // One beat per clock; length and flags are held by the handshake
  always_comb
  begin
    next_rxAck = rxAck;
    next_rdIdx = rdIdx;
    next_urState = urState;
    next_rxValid = 1'b0;
    next_rxWord = '0;
    next_rxLast = 1'b0;
    next_rxError = 1'b0;
    next_rxFc = 1'b0;
    case (urState)
      MPI_UR_IDLE:
      begin
        if (rxDoneSync != rxAck)
        begin
          next_rdIdx = '0;
          next_urState = MPI_UR_DRAIN;
        end
      end
      MPI_UR_DRAIN:
      begin
        next_rxValid = 1'b1;
        next_rxWord = rxMem[rdIdx[AW-1:0]];
        next_rdIdx = rdIdx + 1'b1;
        if (rdIdx == wrIdx - 1'b1)
        begin
          next_rxLast = 1'b1;
          next_rxError = errSeen;
          next_rxFc = fcSeen;
          next_rxAck = rxDoneSync;
          next_urState = MPI_UR_IDLE;
        end
      end
      default: next_urState = MPI_UR_IDLE;
    endcase
  end

  // User receive registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rxAck <= 1'b0;
      rxDoneMeta <= 1'b0;
      rxDoneSync <= 1'b0;
      rdIdx <= '0;
      urState <= MPI_UR_IDLE;
      rxValid <= 1'b0;
      rxWord <= '0;
      rxLast <= 1'b0;
      rxError <= 1'b0;
      rxFalseCarrier <= 1'b0;
    end
    else
    begin
      rxAck <= next_rxAck;
      rxDoneMeta <= rxDone;
      rxDoneSync <= rxDoneMeta;
      rdIdx <= next_rdIdx;
      urState <= next_urState;
      rxValid <= next_rxValid;
      rxWord <= next_rxWord;
      rxLast <= next_rxLast;
      rxError <= next_rxError;
      rxFalseCarrier <= next_rxFc;
    end
  end

endmodule : mpi_mac_port

// ### design/mpi_pkg.sv
// Shared constants, modes and lane helpers for the media pin port
package mpi_pkg;

  typedef enum logic [1:0] {MPI_MII, MPI_RMII, MPI_GMII, MPI_TBI} mpi_mode_t;

  // ----------------------------------------------------------------
  // Timing and reset constants
  // ----------------------------------------------------------------
  localparam int unsigned MPI_LINK_KHZ = 166667;
  localparam int unsigned MPI_TXCLK_KHZ = 25000;
  localparam int unsigned MPI_TXCLK_HALF = MPI_LINK_KHZ / (2 * MPI_TXCLK_KHZ);
  localparam logic [7:0] MPI_DATA_RESET = 8'h00;
  localparam int unsigned MPI_DEPTH_DEFAULT = 64;

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  // Bits carried per symbol in each mode
  function automatic logic [3:0] laneWidth(input mpi_mode_t mode);
    case (mode)
      MPI_MII: laneWidth = 4'h4;
      MPI_RMII: laneWidth = 4'h2;
      default: laneWidth = 4'h8;
    endcase
  endfunction : laneWidth

  // Symbols per byte, minus one, for the last-symbol test
  function automatic logic [1:0] lastSymbol(input mpi_mode_t mode);
    case (mode)
      MPI_MII: lastSymbol = 2'h1;
      MPI_RMII: lastSymbol = 2'h3;
      default: lastSymbol = 2'h0;
    endcase
  endfunction : lastSymbol

  // Lanes that carry data; the rest are driven and read as zero
  function automatic logic [7:0] laneMask(input mpi_mode_t mode);
    case (mode)
      MPI_MII: laneMask = 8'h0F;
      MPI_RMII: laneMask = 8'h03;
      default: laneMask = 8'hFF;
    endcase
  endfunction : laneMask

endpackage : mpi_pkg

// ### design/mpi_media_if.sv
// Pin-level link between the MAC port and its PHY-side partner
`timescale 1ns/100ps
interface mpi_media_if;
  logic linkClock;
  // Device outputs
  logic [7:0] portTransmitDataBus;
  logic portTransmitEnable;
  logic [7:0] devRxData;
  logic devRxValid;
  logic devRxError;
  logic devRxOe;
  logic devCarrierOut;
  logic devCarrierOe;
  logic txClockOut;
  logic txClockOe;
  // Partner outputs
  logic [7:0] phyRxData;
  logic phyRxValid;
  logic phyRxError;
  logic phyCarrierOut;
  logic phyCarrierOe;
  // Resolved pin levels; the emulating device wins the receive pins
  logic [7:0] portReceiveDataBus;
  logic portReceiveValid;
  logic portReceiveError;
  logic portCarrierSense;
  logic portTransmitClock;

  assign portReceiveDataBus = devRxOe ? devRxData : phyRxData;
  assign portReceiveValid = devRxOe ? devRxValid : phyRxValid;
  assign portReceiveError = devRxOe ? devRxError : phyRxError;
  assign portCarrierSense = devCarrierOe ? devCarrierOut : (phyCarrierOe & phyCarrierOut);
  assign portTransmitClock = txClockOe ? txClockOut : linkClock;

  modport device_end (
    input linkClock, portReceiveDataBus, portReceiveValid, portReceiveError, portCarrierSense,
    output portTransmitDataBus, portTransmitEnable, devRxData, devRxValid, devRxError, devRxOe,
    output devCarrierOut, devCarrierOe, txClockOut, txClockOe
  );
  modport phy_end (
    input linkClock, portTransmitDataBus, portTransmitEnable, portCarrierSense,
    output phyRxData, phyRxValid, phyRxError, phyCarrierOut, phyCarrierOe
  );
endinterface : mpi_media_if

// ### design/mpi_phy_end.sv
// PHY-side partner of the media pin port, all on the link clock
`timescale 1ns/100ps
module mpi_phy_end (
  input wire logic rst,
  input wire mpi_pkg::mpi_mode_t mode,
  input wire logic [7:0] lineData,
  input wire logic lineValid,
  input wire logic lineCarrier,
  input wire logic lineError,
  input wire logic lineDetect,
  output logic [7:0] seenData,
  output logic seenEnable,
  mpi_media_if.phy_end media
);
  // ----------------------------------------------------------------
  // Reset crossing into the link domain
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rstLink;

  // Two flops on the level reset
  always_ff @(posedge media.linkClock)
  begin
    rstMeta <= rst;
    rstLink <= rstMeta;
  end

  // ----------------------------------------------------------------
  // Receive pin drive and transmit pin capture
  // ----------------------------------------------------------------
  logic [7:0] next_rxData;
  logic next_rxValid;
  logic next_rxError;
  logic next_carrier;
  logic [7:0] next_seenData;
  logic next_seenEnable;
  logic [7:0] rxData;
  logic rxValid;
  logic rxError;
  logic carrier;

  // Next pin values from the line model
  always_comb
  begin
    next_rxData = lineData & mpi_pkg::laneMask(mode);
    // In RMII the valid pin follows the medium, not the decoded data
    next_rxValid = (mode == mpi_pkg::MPI_RMII) ? lineCarrier : lineValid;
    next_rxError = lineError;
    if (mode == mpi_pkg::MPI_TBI)
    begin
      next_carrier = lineDetect;
    end
    else
    begin
      next_carrier = lineCarrier | lineValid | media.portTransmitEnable;
    end
    next_seenData = media.portTransmitDataBus & mpi_pkg::laneMask(mode);
    next_seenEnable = media.portTransmitEnable;
  end

  // Launch and capture on the rising link edge
  always_ff @(posedge media.linkClock)
  begin
    if (rstLink)
    begin
      rxData <= mpi_pkg::MPI_DATA_RESET;
      rxValid <= 1'b0;
      rxError <= 1'b0;
      carrier <= 1'b0;
      seenData <= mpi_pkg::MPI_DATA_RESET;
      seenEnable <= 1'b0;
    end
    else
    begin
      rxData <= next_rxData;
      rxValid <= next_rxValid;
      rxError <= next_rxError;
      carrier <= next_carrier;
      seenData <= next_seenData;
      seenEnable <= next_seenEnable;
    end
  end

  assign media.phyRxData = rxData;
  assign media.phyRxValid = rxValid;
  assign media.phyRxError = rxError;
  assign media.phyCarrierOut = carrier;
  assign media.phyCarrierOe = 1'b1;

endmodule : mpi_phy_end

// ### verification/mpi_link_props.sv
// Link-side checker for the media pin port
`timescale 1ns/100ps
module mpi_link_props (
  input wire logic linkClock,
  input wire logic rst,
  input wire mpi_pkg::mpi_mode_t mode,
  input wire logic phyEmulation,
  input wire logic [7:0] portTransmitDataBus,
  input wire logic portTransmitEnable,
  input wire logic [7:0] portReceiveDataBus,
  input wire logic portReceiveValid,
  input wire logic portCarrierSense,
  input wire logic devRxOe,
  input wire logic devCarrierOe,
  input wire logic txClockOut,
  input wire logic txClockOe
);
  // ----------------------------------------------------------------
  // Settling count
  // ----------------------------------------------------------------
  logic [2:0] upTime;
  logic [2:0] next_upTime;

  // Link logic leaves reset through a synchroniser, so checks wait a few edges
  always_comb next_upTime = rst ? 3'h0 : upTime + {2'h0, upTime != 3'h7};
  always_ff @(posedge linkClock) upTime <= next_upTime;

  default clocking lcb @(posedge linkClock);
  endclocking
  default disable iff (rst || upTime != 3'h7);

  // ----------------------------------------------------------------
  // Pin rules
  // ----------------------------------------------------------------
  chk_tx_nibble_lanes: assert property (mode == mpi_pkg::MPI_MII |-> portTransmitDataBus[7:4] == 4'h0)
    else $error("upper transmit lanes active in nibble mode");
  chk_tx_dibit_lanes: assert property (mode == mpi_pkg::MPI_RMII |-> portTransmitDataBus[7:2] == 6'h00)
    else $error("upper transmit lanes active in dibit mode");
  chk_enable_whole_byte: assert property ($rose(portTransmitEnable) && mode == mpi_pkg::MPI_MII |-> portTransmitEnable[*2])
    else $error("transmit enable dropped inside a byte");
  chk_enable_dibit_run: assert property ($rose(portTransmitEnable) && mode == mpi_pkg::MPI_RMII |-> portTransmitEnable[*4])
    else $error("transmit enable dropped inside a dibit byte");
  chk_emul_tx_quiet: assert property (phyEmulation |-> !portTransmitEnable)
    else $error("transmit enable driven while emulating");
  chk_rx_drive_dir: assert property (devRxOe == phyEmulation)
    else $error("receive pin drive does not follow emulation");
  chk_carrier_dir: assert property (devCarrierOe == phyEmulation)
    else $error("carrier pin direction does not follow emulation");
  chk_emul_rx_lanes: assert property (devRxOe && mode == mpi_pkg::MPI_RMII |-> portReceiveDataBus[7:2] == 6'h00)
    else $error("upper receive lanes driven in dibit mode");
  chk_emul_valid_run: assert property (devRxOe && mode == mpi_pkg::MPI_MII && $rose(portReceiveValid) |-> portReceiveValid[*2])
    else $error("driven receive valid dropped inside a byte");
  chk_txclk_owner: assert property (txClockOe |-> mode == mpi_pkg::MPI_MII && phyEmulation)
    else $error("transmit clock driven outside nibble emulation");
  chk_txclk_half: assert property (txClockOe && $rose(txClockOut) |-> txClockOut[*3] ##1 !txClockOut)
    else $error("generated transmit clock half period wrong");
  chk_line_detect: assert property (mode == mpi_pkg::MPI_TBI && devCarrierOe |-> portCarrierSense)
    else $error("line detect not driven in code-group emulation");
  chk_carrier_on_tx: assert property (!devCarrierOe && mode != mpi_pkg::MPI_TBI && portTransmitEnable |=> portCarrierSense)
    else $error("carrier sense low while transmitting");
endmodule : mpi_link_props

// ### verification/tb_top.sv
// Self-checking bench: MAC port and PHY end joined over the media pins
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic rst = 1'b1;
  mpi_pkg::mpi_mode_t mode = mpi_pkg::MPI_MII;
  logic phyEmulation = 1'b0;
  logic txWrite = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic txLast = 1'b0;
  logic txReady, rxValid, rxLast, rxError, rxFalseCarrier, carrierSeen, seenEnable;
  logic [9:0] rxWord;
  logic [7:0] seenData;
  logic [7:0] lineData = 8'h00;
  logic lineValid = 1'b0, lineCarrier = 1'b0, lineError = 1'b0, lineDetect = 1'b0;
  int fails = 0;
  int checks = 0;
  int w = 4;
  int pos = 0;
  logic [7:0] mk = 8'h0F;
  logic [7:0] acc = 8'h00;
  logic [15:0] expQ[$], gotQ[$], sentQ[$], outQ[$];

  always #50 clock = ~clock;
  always #3 linkClock = ~linkClock;

  mpi_media_if u_mpi_media_if ();
  assign u_mpi_media_if.linkClock = linkClock;

  mpi_mac_port #(.DEPTH(8)) u_mpi_mac_port (.clock(clock), .rst(rst), .mode(mode), .phyEmulation(phyEmulation),
    .txWrite(txWrite), .txByte(txByte), .txLast(txLast), .txReady(txReady), .rxValid(rxValid), .rxWord(rxWord),
    .rxLast(rxLast), .rxError(rxError), .rxFalseCarrier(rxFalseCarrier), .carrierSeen(carrierSeen),
    .media(u_mpi_media_if.device_end));
  mpi_phy_end u_mpi_phy_end (.rst(rst), .mode(mode), .lineData(lineData), .lineValid(lineValid),
    .lineCarrier(lineCarrier), .lineError(lineError), .lineDetect(lineDetect), .seenData(seenData),
    .seenEnable(seenEnable), .media(u_mpi_media_if.phy_end));
  mpi_link_props u_mpi_link_props (.linkClock(linkClock), .rst(rst), .mode(mode), .phyEmulation(phyEmulation),
    .portTransmitDataBus(u_mpi_media_if.portTransmitDataBus), .portTransmitEnable(u_mpi_media_if.portTransmitEnable),
    .portReceiveDataBus(u_mpi_media_if.portReceiveDataBus), .portReceiveValid(u_mpi_media_if.portReceiveValid),
    .portCarrierSense(u_mpi_media_if.portCarrierSense), .devRxOe(u_mpi_media_if.devRxOe),
    .devCarrierOe(u_mpi_media_if.devCarrierOe), .txClockOut(u_mpi_media_if.txClockOut),
    .txClockOe(u_mpi_media_if.txClockOe));

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Rebuild bytes leaving the port, lowest lane first; a partial byte is dropped
  always @(posedge linkClock)
  begin
    if (phyEmulation ? u_mpi_media_if.portReceiveValid : seenEnable)
    begin
      acc = acc | (((phyEmulation ? u_mpi_media_if.portReceiveDataBus : seenData) & mk) << pos);
      pos = pos + w;
      if (pos == 8)
      begin
        outQ.push_back({8'h00, acc});
        acc = 8'h00;
        pos = 0;
      end
    end
    else
    begin
      acc = 8'h00;
      pos = 0;
    end
  end

  // Collect user-side receive reports with their flags
  always @(posedge clock)
    if (rxValid === 1'b1)
      gotQ.push_back({3'h0, rxFalseCarrier, rxError, rxLast, rxWord});

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic match(ref logic [15:0] g[$], ref logic [15:0] e[$]);
    for (int k = 0; k < 300 && g.size() < e.size(); k++) @(posedge clock) #1;
    check(16'(g.size()), 16'(e.size()));
    while (g.size() > 0 && e.size() > 0) check(g.pop_front(), e.pop_front());
    g.delete();
    e.delete();
  endtask : match

  task automatic print_verdict();
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Mode and emulation only change under reset, as they are static levels
  task automatic restart(input mpi_pkg::mpi_mode_t m, input logic emu);
    rst = 1'b1;
    mode = m;
    phyEmulation = emu;
    w = (m == mpi_pkg::MPI_MII) ? 4 : (m == mpi_pkg::MPI_RMII) ? 2 : 8;
    mk = 8'(8'hFF >> (8 - w));
    repeat (6) @(posedge clock) #1;
    rst = 1'b0;
    repeat (2) @(posedge clock) #1;
  endtask : restart

  // Writes wait on ready, so a frame queued behind a busy link is held off
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      txByte = 8'($urandom);
      txLast = (i == n - 1);
      txWrite = 1'b1;
      sentQ.push_back({8'h00, txByte});
      for (int k = 0; k < 400 && txReady !== 1'b1; k++) @(posedge clock) #1;
      @(posedge clock) #1;
    end
    txWrite = 1'b0;
    txLast = 1'b0;
    for (int k = 0; k < 400 && txReady !== 1'b1; k++) @(posedge clock) #1;
    match(outQ, sentQ);
  endtask : send

  // Unused lanes carry noise that the port must ignore
  task automatic recv(input int n, input int errAt);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      for (int s = 0; s < 8; s += w)
      begin
        @(posedge linkClock) #1;
        lineData = ((b >> s) & mk) | (8'($urandom) & ~mk);
        {lineValid, lineCarrier, lineDetect} = 3'h7;
        lineError = (i == errAt && s == 0);
      end
      expQ.push_back({4'h0, (i == n - 1) && errAt >= 0, i == n - 1, 1'b0, mode == mpi_pkg::MPI_TBI, b});
    end
    @(posedge linkClock) #1;
    {lineValid, lineCarrier, lineDetect, lineError} = 4'h0;
    match(gotQ, expQ);
  endtask : recv

  task automatic idleEvents();
    logic [7:0] b;
    b = 8'($urandom);
    @(posedge linkClock) #1;
    lineData = b;
    lineError = 1'b1;
    @(posedge linkClock) #1;
    lineError = 1'b0;
    expQ.push_back({4'h1, 1'b0, 1'b1, 2'h0, b & mk});
    match(gotQ, expQ);
    if (mode != mpi_pkg::MPI_RMII)
    begin
      @(posedge linkClock) #1;
      lineCarrier = 1'b1;
      repeat (8) @(posedge clock) #1;
      check(16'(carrierSeen), 16'h0001);
      lineCarrier = 1'b0;
      repeat (8) @(posedge clock) #1;
      check(16'(carrierSeen), 16'h0000);
    end
  endtask : idleEvents

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(28));
    for (int e = 0; e < 2; e++)
      for (int m = 0; m < 4; m++)
      begin
        restart(mpi_pkg::mpi_mode_t'(m), e[0]);
        send($urandom_range(7, 1));
        send(8);
        if (e == 0)
        begin
          recv(6, -1);
          if (m != 3)
          begin
            recv(5, 2);
            idleEvents();
          end
        end
        else
          check(16'(carrierSeen), 16'(m == 3));
      end
    print_verdict();
  end

  // Whole run takes well under a millisecond; far beyond that means a hang
  initial
  begin
    #3000000;
    fails++;
    print_verdict();
  end
endmodule : tb_top
